// ### design/efx_control.v
// Behaviour
// - Select press flips edited processor; other soft controls act on it
// - Insert buttons place selected processor at prog1, prog2, aux, main
// - Same effect type never loaded in both processors at once
// - Cue button toggles global cue flag, kept across processor switching
// - On button toggles selected processor; when on effect goes to master
// - Joystick press toggles its mode bit: off transform, on parameter
// - No second function defined: first joystick press changes nothing
// - Footswitch taps tempo, toggles effect, flips processor selection
// - Headphone cue needs selected processor, cue flag, pan and master cue
// - Main or aux inserted processor cues only with master cue on
// - Hold echo heard in phones only when on and sent to master
// - Echoes fed after fader; other effects fed regardless of fader
// - Track tempo tag drives sweep rate and shows locked indication
// - Tempo defaults 120 BPM; tapping sets 24 to 480 in 0.1 steps
// - Single tap restarts sweep phase aligned to tempo
// - First encoder sets cutoff from 529 Hz, limited 31.5 Hz to 16 kHz
// - First joystick in mode selects multiplier 16 down to one quarter
// - Second encoder sets resonance 0.7 to 3.0
// - Second encoder second mode sets depth up to 4.5 octaves
// - Wet default full; left/right adjust; up/down momentary wet/dry
// - Separate stored parameters for low, band and high pass filters
// - Crusher: encoder one drive, encoder two rate, second function bits
// - Shared insert: pre-fader first; both filters then processor one first
`timescale 1ns/1ps
`include "efx_regs.vh"
module efx_control (
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire        select_button,
  input  wire        insert_prog1_button,
  input  wire        insert_prog2_button,
  input  wire        insert_aux_button,
  input  wire        insert_main_button,
  input  wire        effect_cue_button,
  input  wire        processor_on_button,
  input  wire        first_joystick_press,
  input  wire        second_joystick_press,
  input  wire [3:0]  second_joystick_dir,
  input  wire        first_encoder_up,
  input  wire        first_encoder_down,
  input  wire        first_encoder_tap,
  input  wire        second_encoder_up,
  input  wire        second_encoder_down,
  input  wire        first_joystick_left,
  input  wire        first_joystick_right,
  input  wire        foot_tap,
  input  wire        foot_toggle,
  input  wire        foot_select,
  input  wire        tap_tempo_valid,
  input  wire [12:0] tap_tempo,
  input  wire        tag_valid,
  input  wire [12:0] tag_tempo,
  input  wire        cue_pan_ok,
  input  wire        master_cue_on,
  input  wire        fader_open,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         selected_proc,
  output reg  [2:0]  insert0,
  output reg  [2:0]  insert1,
  output reg         proc_on0,
  output reg         proc_on1,
  output reg         cue_flag,
  output reg         mode1,
  output reg         mode2,
  output reg         phones_effect,
  output reg         feed0,
  output reg         feed1,
  output reg         proc1_first,
  output reg         tempo_locked,
  output reg  [12:0] sweep_tempo,
  output reg         sweep_restart,
  output reg  [8:0]  cutoff_out,
  output reg  [7:0]  reso_out,
  output reg  [7:0]  depth_out,
  output reg  [7:0]  wet_out,
  output reg  [2:0]  mult_out
);

  // Type classification helpers and saturating step
  function is_echo;
    input [3:0] t;
    begin
      is_echo = (t <= `EFX_T_HPHOLD);
    end
  endfunction
  function is_hold;
    input [3:0] t;
    begin
      is_hold = (t == `EFX_T_HOLD) || (t == `EFX_T_HPHOLD);
    end
  endfunction
  function is_filt;
    input [3:0] t;
    begin
      is_filt = (t >= `EFX_T_LPF) && (t <= `EFX_T_HPF);
    end
  endfunction
  function [7:0] sat_step;
    input [7:0] v;
    input       up;
    input       dn;
    input [7:0] lo;
    input [7:0] hi;
    begin
      sat_step = v;
      if (up && v < hi)
        sat_step = v + 8'h01;
      else if (dn && v > lo)
        sat_step = v - 8'h01;
    end
  endfunction

  reg  [3:0]  type0;
  reg  [3:0]  type1;
  reg  [8:0]  cut_reg  [0:2];
  reg  [7:0]  res_reg  [0:2];
  reg  [7:0]  dep_reg  [0:2];
  reg  [7:0]  wet_reg  [0:2];
  reg  [7:0]  drive_reg;
  reg  [7:0]  rate_reg;
  reg  [7:0]  bits_reg;
  reg  [12:0] man_tempo;
  reg  [2:0]  mult_reg;
  reg         aw_hold;
  reg         w_hold;
  reg  [31:0] aw_addr;
  reg  [32:0] w_data;
  integer     i;

  wire [3:0]  sel_type = selected_proc ? type1 : type0;
  wire        sel_filt = is_filt(sel_type);
  wire [1:0]  fidx     = sel_filt ? sel_type[1:0] : 2'd0;
  // Second function present: first joystick for filters and echoes, second always
  wire        j1_has   = sel_filt || is_echo(sel_type);
  wire        enc2_sec = mode2;
  wire        do_sel   = select_button | foot_select;
  wire        do_on    = processor_on_button | foot_toggle;
  wire        any_tap  = first_encoder_tap | foot_tap;
  wire [7:0]  mult_nx  = sat_step({5'h00, mult_reg}, first_joystick_right, first_joystick_left,
                                  8'h00, {5'h00, `EFX_MUL_MAX});

  // AXI write acceptance: hold each channel until both are present
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire        aw_ok    = aw_hold || (s_axi_awvalid && s_axi_awready);
  wire        w_ok     = w_hold || (s_axi_wvalid && s_axi_wready);
  wire [31:0] wa       = aw_hold ? aw_addr : s_axi_awaddr;
  wire [31:0] wd       = w_hold ? w_data[31:0] : s_axi_wdata;
  wire        wr_go    = aw_ok && w_ok;
  wire [3:0]  wr_t0    = wd[3:0];
  wire [3:0]  wr_t1    = wd[7:4];
  wire        ws0      = w_hold ? w_data[32] : s_axi_wstrb[0];
  wire        wr_type  = wr_go && (wa[11:0] == `EFX_TYPE_ADDR) && ws0;
  wire        wr_map   = (wa[11:0] == `EFX_TYPE_ADDR) || (wa[11:0] == `EFX_CTRL_ADDR);

  // Bus channel capture and write response
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_hold      <= 1'b0;
      w_hold       <= 1'b0;
      aw_addr      <= 32'h0000_0000;
      w_data       <= 33'h0_0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else begin
      if (wr_go) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Duplicate type write refused with slave error
        s_axi_bresp  <= (!wr_map || (wr_type && wr_t0 == wr_t1)) ? 2'b10 : 2'b00;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_hold <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_hold <= 1'b1;
          w_data <= {s_axi_wstrb[0], s_axi_wdata};
        end
        if (s_axi_bvalid && s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read path
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'b00;
      if (s_axi_araddr[11:0] == `EFX_TYPE_ADDR)
        s_axi_rdata <= {24'h00_0000, type1, type0};
      else if (s_axi_araddr[11:0] == `EFX_STATUS_ADDR)
        s_axi_rdata <= {20'h0_0000, insert1, insert0, mode2, mode1, cue_flag,
                        proc_on1, proc_on0, selected_proc};
      else if (s_axi_araddr[11:0] == `EFX_TEMPO_ADDR)
        s_axi_rdata <= {15'h0000, tempo_locked, mult_reg, sweep_tempo};
      else if (s_axi_araddr[11:0] == `EFX_PARAM_ADDR)
        s_axi_rdata <= {cutoff_out[7:0], reso_out, depth_out, wet_out};
      else if (s_axi_araddr[11:0] == `EFX_PARAM1_ADDR)
        s_axi_rdata <= {8'h00, drive_reg, rate_reg, bits_reg};
      else if (s_axi_araddr[11:0] == `EFX_CTRL_ADDR)
        s_axi_rdata <= 32'h0000_0000;
      else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= 2'b10;
      end
    end else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Panel state: selection, inserts, on, cue, modes, types
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      selected_proc <= 1'b0;
      cue_flag      <= 1'b0;
      proc_on0      <= 1'b0;
      proc_on1      <= 1'b0;
      mode1         <= 1'b0;
      mode2         <= 1'b0;
      insert0       <= `EFX_INS_NONE;
      insert1       <= `EFX_INS_NONE;
      type0         <= `EFX_TYPE0_DEF;
      type1         <= `EFX_TYPE1_DEF;
    end else begin
      if (do_sel)
        selected_proc <= ~selected_proc;
      if (effect_cue_button)
        cue_flag <= ~cue_flag;
      if (do_on && !selected_proc)
        proc_on0 <= ~proc_on0;
      if (do_on && selected_proc)
        proc_on1 <= ~proc_on1;
      // Insert decode for selected processor
      if (insert_prog1_button) begin
        if (selected_proc) insert1 <= `EFX_INS_PROG1; else insert0 <= `EFX_INS_PROG1;
      end else if (insert_prog2_button) begin
        if (selected_proc) insert1 <= `EFX_INS_PROG2; else insert0 <= `EFX_INS_PROG2;
      end else if (insert_aux_button) begin
        if (selected_proc) insert1 <= `EFX_INS_AUX; else insert0 <= `EFX_INS_AUX;
      end else if (insert_main_button) begin
        if (selected_proc) insert1 <= `EFX_INS_MAIN; else insert0 <= `EFX_INS_MAIN;
      end
      if (first_joystick_press && j1_has)
        mode1 <= ~mode1;
      if (second_joystick_press)
        mode2 <= ~mode2;
      if (wr_type && wr_t0 != wr_t1) begin
        type0 <= wr_t0;
        type1 <= wr_t1;
      end
    end
  end

  // Parameter sets, tempo and multiplier
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (i = 0; i < 3; i = i + 1) begin
        cut_reg[i] <= `EFX_CUT_DEF;
        res_reg[i] <= `EFX_RES_DEF;
        dep_reg[i] <= 8'h00;
        wet_reg[i] <= `EFX_WET_DEF;
      end
      drive_reg     <= 8'h00;
      rate_reg      <= 8'h00;
      bits_reg      <= 8'h00;
      man_tempo     <= `EFX_BPM_DEF;
      mult_reg      <= `EFX_MUL_ONE;
      sweep_restart <= 1'b0;
    end else begin
      sweep_restart <= any_tap;
      if (tap_tempo_valid && tap_tempo >= `EFX_BPM_MIN && tap_tempo <= `EFX_BPM_MAX)
        man_tempo <= tap_tempo;
      if (sel_filt) begin
        // Cutoff on first encoder, limited range
        if (first_encoder_up && cut_reg[fidx] < `EFX_CUT_MAX)
          cut_reg[fidx] <= cut_reg[fidx] + 9'h001;
        else if (first_encoder_down && cut_reg[fidx] != 9'h000)
          cut_reg[fidx] <= cut_reg[fidx] - 9'h001;
        if (!enc2_sec)
          res_reg[fidx] <= sat_step(res_reg[fidx], second_encoder_up, second_encoder_down,
                                    `EFX_RES_MIN, `EFX_RES_MAX);
        else
          dep_reg[fidx] <= sat_step(dep_reg[fidx], second_encoder_up, second_encoder_down,
                                    8'h00, `EFX_DEP_MAX);
        if (mode2)
          wet_reg[fidx] <= sat_step(wet_reg[fidx], second_joystick_dir[0],
                                    second_joystick_dir[1], 8'h00, `EFX_WET_FULL);
        if (mode1)
          mult_reg <= mult_nx[2:0];
      end else if (sel_type == `EFX_T_CRUSH) begin
        drive_reg <= sat_step(drive_reg, first_encoder_up, first_encoder_down,
                              8'h00, 8'hFF);
        if (!enc2_sec)
          rate_reg <= sat_step(rate_reg, second_encoder_up, second_encoder_down,
                               8'h00, 8'hFF);
        else
          bits_reg <= sat_step(bits_reg, second_encoder_up, second_encoder_down,
                               8'h00, 8'hFF);
      end
    end
  end

  // Derived outputs: tempo, wet override, routing and cue
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tempo_locked  <= 1'b0;
      sweep_tempo   <= `EFX_BPM_DEF;
      cutoff_out    <= `EFX_CUT_DEF;
      reso_out      <= `EFX_RES_DEF;
      depth_out     <= 8'h00;
      wet_out       <= `EFX_WET_DEF;
      mult_out      <= `EFX_MUL_ONE;
      phones_effect <= 1'b0;
      feed0         <= 1'b0;
      feed1         <= 1'b0;
      proc1_first   <= 1'b1;
    end else begin
      tempo_locked <= tag_valid;
      sweep_tempo  <= tag_valid ? tag_tempo : man_tempo;
      cutoff_out   <= cut_reg[fidx];
      reso_out     <= res_reg[fidx];
      depth_out    <= dep_reg[fidx];
      mult_out     <= mult_reg;
      // Up momentary wet, down momentary dry, else stored ratio
      if (mode2 && second_joystick_dir[2])
        wet_out <= `EFX_WET_FULL;
      else if (mode2 && second_joystick_dir[3])
        wet_out <= 8'h00;
      else
        wet_out <= wet_reg[fidx];
      feed0 <= is_echo(type0) ? fader_open : 1'b1;
      feed1 <= is_echo(type1) ? fader_open : 1'b1;
      // Order at shared insert
      if (is_echo(type0) && !is_echo(type1))
        proc1_first <= 1'b0;
      else
        proc1_first <= 1'b1;
      if (is_hold(sel_type))
        phones_effect <= selected_proc ? proc_on1 : proc_on0;
      else
        phones_effect <= cue_flag && cue_pan_ok && master_cue_on;
    end
  end

endmodule // efx_control

// ### inc/efx_regs.vh
`ifndef EFX_REGS_VH
`define EFX_REGS_VH
// Register byte offsets
`define EFX_CTRL_ADDR      12'h000
`define EFX_STATUS_ADDR    12'h004
`define EFX_TYPE_ADDR      12'h008
`define EFX_TEMPO_ADDR     12'h00C
`define EFX_PARAM_ADDR     12'h010
`define EFX_PARAM1_ADDR    12'h014
// Effect type codes
`define EFX_T_ECHO         4'h0
`define EFX_T_HOLD         4'h1
`define EFX_T_HPECHO       4'h2
`define EFX_T_HPHOLD       4'h3
`define EFX_T_LPF          4'h4
`define EFX_T_BPF          4'h5
`define EFX_T_HPF          4'h6
`define EFX_T_PHASER       4'h7
`define EFX_T_FLANGER      4'h8
`define EFX_T_CRUSH        4'h9
// Insert points
`define EFX_INS_NONE       3'h0
`define EFX_INS_PROG1      3'h1
`define EFX_INS_PROG2      3'h2
`define EFX_INS_AUX        3'h3
`define EFX_INS_MAIN       3'h4
// Tempo in tenths of BPM
`define EFX_BPM_DEF        13'h04B0
`define EFX_BPM_MIN        13'h00F0
`define EFX_BPM_MAX        13'h12C0
// Cutoff step index, 0 is 31.5 Hz, 9 octaves over 480 steps, default 529 Hz
`define EFX_CUT_DEF        9'h0D9
`define EFX_CUT_MAX        9'h1E0
// Resonance in tenths
`define EFX_RES_MIN        8'h07
`define EFX_RES_MAX        8'h1E
`define EFX_RES_DEF        8'h07
// Depth in tenths of octave, 0 to 45
`define EFX_DEP_MAX        8'h2D
// Wet ratio 0..100
`define EFX_WET_FULL       8'h64
`define EFX_WET_DEF        8'h64
// Multiplier index 0..7 for 16,8,4,2,1,3/4,1/2,1/4
`define EFX_MUL_ONE        3'h4
`define EFX_MUL_MAX        3'h7
// Reset values of type registers
`define EFX_TYPE0_DEF      4'h0
`define EFX_TYPE1_DEF      4'h4
`endif

// ### tb/efx_checker.sv
`timescale 1ns/1ps
`include "efx_regs.vh"
module efx_checker (
  input wire        sys_clk,
  input wire        sys_rst,
  input wire        select_button,
  input wire        foot_select,
  input wire        effect_cue_button,
  input wire        processor_on_button,
  input wire        foot_toggle,
  input wire        insert_prog1_button,
  input wire        first_encoder_tap,
  input wire        cue_pan_ok,
  input wire        master_cue_on,
  input wire        selected_proc,
  input wire [2:0]  insert0,
  input wire        proc_on0,
  input wire        proc_on1,
  input wire        cue_flag,
  input wire        phones_effect,
  input wire [12:0] sweep_tempo,
  input wire        sweep_restart,
  input wire [8:0]  cutoff_out,
  input wire [7:0]  reso_out,
  input wire [7:0]  wet_out
);
  // All checks on the system clock, quiet in reset
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_sel_flip: assert property (select_button && !foot_select |=>
    selected_proc != $past(selected_proc)) else $error("Select press did not flip");
  a_foot_flip: assert property (foot_select && !select_button |=>
    selected_proc != $past(selected_proc)) else $error("Foot select did not flip");
  a_sel_hold: assert property (!select_button && !foot_select |=>
    $stable(selected_proc)) else $error("Selection moved without a press");
  a_cue_toggle: assert property (effect_cue_button |=>
    cue_flag != $past(cue_flag)) else $error("Cue press did not toggle");
  a_cue_keep: assert property (select_button && !effect_cue_button |=>
    $stable(cue_flag)) else $error("Cue flag moved on select");
  a_on_selected: assert property (processor_on_button && !foot_toggle && !selected_proc |=>
    proc_on0 != $past(proc_on0) && $stable(proc_on1)) else $error("On press wrong target");
  a_ins_prog1: assert property (insert_prog1_button && !selected_proc |=>
    insert0 == `EFX_INS_PROG1) else $error("Insert one not applied");
  a_tap_restart: assert property (first_encoder_tap |=> sweep_restart)
    else $error("Tap gave no sweep restart");
  a_param_range: assert property (sweep_tempo >= `EFX_BPM_MIN && sweep_tempo <= `EFX_BPM_MAX
    && cutoff_out <= `EFX_CUT_MAX && reso_out >= `EFX_RES_MIN && reso_out <= `EFX_RES_MAX
    && wet_out <= `EFX_WET_FULL) else $error("Parameter out of range");
  a_phones_cause: assert property (phones_effect |->
    $past(cue_flag && cue_pan_ok && master_cue_on) || $past(proc_on0 || proc_on1))
    else $error("Phones effect without cause");
  // Main scenarios reached
  c_phones: cover property (phones_effect);
  c_restart: cover property (sweep_restart);
  c_proc_two_on: cover property (selected_proc && proc_on1);
endmodule // efx_checker

bind efx_control efx_checker efx_checker_inst (.*);

// ### tb/efx_panel.sv
`timescale 1ns/1ps
module efx_panel (
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire        go,
  input  wire [3:0]  code,
  output reg  [15:0] btn
);
  // One-cycle button pulse per request, all released between presses
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      btn <= 16'h0000;
    end else begin
      btn <= go ? (16'h0001 << code) : 16'h0000;
    end
  end
endmodule // efx_panel

// ### tb/testbench.sv
`timescale 1ns/1ps
`include "efx_regs.vh"
module testbench;
  logic        sys_clk, sys_rst, go, tap_tempo_valid, tag_valid, cue_pan_ok, master_cue_on;
  logic        fader_open, first_joystick_left, first_joystick_right, foot_tap;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [3:0]  code, second_joystick_dir, s_axi_wstrb;
  logic [12:0] tap_tempo, tag_tempo;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, rng;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         selected_proc, proc_on0, proc_on1, cue_flag, mode1, mode2, phones_effect;
  wire         feed0, feed1, proc1_first, tempo_locked, sweep_restart;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [2:0]   insert0, insert1, mult_out;
  wire [7:0]   reso_out, depth_out, wet_out;
  wire [8:0]   cutoff_out;
  wire [12:0]  sweep_tempo;
  wire [15:0]  btn;
  wire [31:0]  s_axi_rdata;
  int          num_errors, num_checks, cyc, m_sel, m_cue, m, i, k, s;
  int          m_on[2], m_ins[2], tv[6];

  // Panel model and device
  efx_panel efx_panel_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .go(go), .code(code), .btn(btn));
  efx_control efx_control_inst (
    .select_button(btn[0]), .insert_prog1_button(btn[1]), .insert_prog2_button(btn[2]),
    .insert_aux_button(btn[3]), .insert_main_button(btn[4]), .effect_cue_button(btn[5]),
    .processor_on_button(btn[6]), .first_joystick_press(btn[7]), .second_joystick_press(btn[8]),
    .first_encoder_up(btn[9]), .first_encoder_down(btn[10]), .first_encoder_tap(btn[11]),
    .second_encoder_up(btn[12]), .second_encoder_down(btn[13]), .foot_select(btn[14]),
    .foot_toggle(btn[15]), .*);

  // Compare and count
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", n, e, g);
    end
  endtask

  // Xorshift source
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  // One press through the panel, then settle
  task automatic press(input int c);
    @(posedge sys_clk);
    go   <= 1'b1;
    code <= c[3:0];
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // AXI4-Lite access; ready sampled mid-cycle, released at the taking edge
  task automatic axi(input logic we, input logic [31:0] a, d, input logic [1:0] er);
    logic aw, w, ar, b, r;
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_araddr  <= a;
    s_axi_wdata   <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{we}};
    {s_axi_arvalid, s_axi_rready} <= {2{!we}};
    do begin
      @(negedge sys_clk);
      aw = s_axi_awvalid && s_axi_awready;
      w  = s_axi_wvalid && s_axi_wready;
      ar = s_axi_arvalid && s_axi_arready;
      b  = s_axi_bvalid && s_axi_bready;
      r  = s_axi_rvalid && s_axi_rready;
      if (b) chk("bresp", er, s_axi_bresp);
      if (r) chk("rresp", er, s_axi_rresp);
      if (r && er == 2'b00) chk("rdata", d, s_axi_rdata);
      @(posedge sys_clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (ar) s_axi_arvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
      if (r) s_axi_rready <= 1'b0;
    end while (!b && !r);
  endtask

  task automatic print_verdict();
    $display("Checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Clock at 40 MHz
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      $display("Error timeout");
      print_verdict();
    end
  end

  // Main sequence
  initial begin
    {go, tap_tempo_valid, tag_valid, cue_pan_ok, master_cue_on, fader_open, foot_tap} = '0;
    {first_joystick_left, first_joystick_right, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, code, second_joystick_dir} = '0;
    {tap_tempo, tag_tempo, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hF;
    rng = 32'h0000_0037;
    sys_rst = 1'b1;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    chk("sel", 0, selected_proc);
    chk("cue and on", 0, {cue_flag, proc_on1, proc_on0});
    chk("modes", 0, {mode2, mode1});
    chk("tempo", `EFX_BPM_DEF, sweep_tempo);
    chk("cutoff", `EFX_CUT_DEF, cutoff_out);
    chk("wet", `EFX_WET_DEF, wet_out);
    axi(0, 32'h0000_0008, 32'h0000_0040, 2'b00);
    axi(1, 32'h0000_0000, 32'h0000_FFFF, 2'b00);
    axi(0, 32'h0000_0000, 32'h0000_0000, 2'b00);
    axi(0, 32'h0000_0100, 32'h0000_0000, 2'b10);
    axi(1, 32'h0000_0100, 32'h0000_0000, 2'b10);
    $display("Test reset done");
    for (i = 0; i < 8; i++) begin
      k = xs() % 3;
      press(k == 0 ? 0 : (k == 1 ? 5 : 14));
      m_sel ^= (k != 1);
      m_cue ^= (k == 1);
      chk("sel", m_sel, selected_proc);
      chk("cue", m_cue, cue_flag);
    end
    $display("Test select done");
    for (s = 0; s < 2; s++) begin
      if (m_sel != s) press(0);
      m_sel = s;
      for (k = 1; k < 5; k++) begin
        press(k);
        m_ins[s] = k;
        chk("inserts", m_ins[1] * 8 + m_ins[0], {insert1, insert0});
      end
      for (k = 0; k < 2; k++) begin
        press(k ? 15 : 6);
        m_on[s] ^= 1;
        chk("on", m_on[1] * 2 + m_on[0], {proc_on1, proc_on0});
      end
    end
    $display("Test insert done");
    if (!m_cue) press(5);
    cue_pan_ok <= 1'b1;
    master_cue_on <= 1'b1;
    tick(3);
    chk("phones", 1, phones_effect);
    master_cue_on <= 1'b0;
    tick(3);
    chk("phones", 0, phones_effect);
    {master_cue_on, cue_pan_ok} <= 2'b10;
    tick(3);
    chk("phones", 0, phones_effect);
    fader_open <= 1'b0;
    tick(3);
    chk("feed", 2'b10, {feed1, feed0});
    fader_open <= 1'b1;
    tick(3);
    chk("feed", 2'b11, {feed1, feed0});
    axi(1, 32'h0000_0008, 32'h0000_0044, 2'b10);
    axi(0, 32'h0000_0008, 32'h0000_0040, 2'b00);
    chk("order", 0, proc1_first);
    axi(1, 32'h0000_0008, 32'h0000_0054, 2'b00);
    tick(3);
    chk("order", 1, proc1_first);
    axi(1, 32'h0000_0008, 32'h0000_0040, 2'b00);
    axi(1, 32'h0000_0008, 32'h0000_0010, 2'b00);
    cue_pan_ok <= 1'b1;
    tick(3);
    chk("hold phones", 0, phones_effect);
    press(6);
    chk("hold phones", 1, phones_effect);
    axi(1, 32'h0000_0008, 32'h0000_0040, 2'b00);
    $display("Test cue and order done");
    tv = '{240, 4801, 4800, 239, 0, 0};
    m = `EFX_BPM_DEF;
    for (i = 0; i < 6; i++) begin
      if (i > 3) tv[i] = xs() % 5000;
      tap_tempo <= tv[i][12:0];
      tap_tempo_valid <= 1'b1;
      @(posedge sys_clk);
      tap_tempo_valid <= 1'b0;
      tick(3);
      if (tv[i] >= 240 && tv[i] <= 4800) m = tv[i];
      chk("tempo", m, sweep_tempo);
    end
    tag_tempo <= 13'h05DC;
    tag_valid <= 1'b1;
    tick(4);
    chk("lock", 1, tempo_locked);
    chk("tempo", 13'h05DC, sweep_tempo);
    axi(0, 32'h0000_000C, 32'h0001_85DC, 2'b00);
    tag_valid <= 1'b0;
    press(11);
    foot_tap <= 1'b1;
    @(posedge sys_clk);
    foot_tap <= 1'b0;
    @(negedge sys_clk);
    chk("restart", 1, sweep_restart);
    $display("Test tempo done");
    m = `EFX_CUT_DEF;
    for (i = 0; i < 710; i++) begin
      press(i < 220 ? 10 : 9);
      m = i < 220 ? (m > 0 ? m - 1 : 0) : (m < 480 ? m + 1 : 480);
      if (i == 219 || i == 709) chk("cutoff", m, cutoff_out);
    end
    for (i = 0; i < 25; i++) press(12);
    chk("reso", `EFX_RES_MAX, reso_out);
    axi(1, 32'h0000_0008, 32'h0000_0050, 2'b00);
    tick(3);
    chk("reso", `EFX_RES_DEF, reso_out);
    axi(1, 32'h0000_0008, 32'h0000_0040, 2'b00);
    tick(3);
    chk("reso", `EFX_RES_MAX, reso_out);
    press(8);
    chk("mode2", 1, mode2);
    second_joystick_dir <= 4'h2;
    tick(110);
    second_joystick_dir <= 4'h4;
    tick(3);
    chk("wet", `EFX_WET_FULL, wet_out);
    second_joystick_dir <= 4'h0;
    tick(3);
    chk("wet", 0, wet_out);
    for (i = 0; i < 46; i++) press(12);
    chk("depth", `EFX_DEP_MAX, depth_out);
    press(7);
    chk("mode1", 1, mode1);
    first_joystick_left <= 1'b1;
    tick(6);
    chk("mult", 0, mult_out);
    {first_joystick_left, first_joystick_right} <= 2'b01;
    tick(10);
    chk("mult", `EFX_MUL_MAX, mult_out);
    first_joystick_right <= 1'b0;
    axi(1, 32'h0000_0008, 32'h0000_0070, 2'b00);
    tick(3);
    m = mode1;
    press(7);
    chk("mode1", m, mode1);
    axi(1, 32'h0000_0008, 32'h0000_0090, 2'b00);
    for (i = 0; i < 3; i++) press(9);
    press(12);
    axi(0, 32'h0000_0014, 32'h0003_0001, 2'b00);
    $display("Test filter done");
    print_verdict();
  end
endmodule // testbench
